// ==== hw/spds_defs.vh ====
// Purpose: Constants for the sensor power down sequencer controller
// Assumes: 9-bit register address, 16-bit register data, SPI mode 0
// Notes:   Register addresses are the sensor's configuration addresses
`ifndef SPDS_DEFS_VH
`define SPDS_DEFS_VH

// Sensor register addresses
`define SPDS_REG_PLL_SOFT_RESET      9'h008
`define SPDS_REG_CLOCK_GEN_RESET     9'h009
`define SPDS_REG_CORE_SOFT_RESET     9'h00A
`define SPDS_REG_PLL_POWER           9'h010
`define SPDS_REG_CLOCK_MGMT_CONFIG   9'h014
`define SPDS_REG_CLOCK_DISTRIBUTION  9'h020
`define SPDS_REG_LOGIC_BLOCK_ENABLE  9'h022
`define SPDS_REG_COLUMN_MUX_ENABLE   9'h028
`define SPDS_REG_FRONT_END_ENABLE    9'h030
`define SPDS_REG_BIAS_ENABLE         9'h040
`define SPDS_REG_CHARGE_PUMP_ENABLE  9'h048
`define SPDS_REG_SERIAL_TX_ENABLE    9'h070
`define SPDS_REG_SEQUENCER_CONTROL   9'h0C0

// Data values
`define SPDS_DATA_ZERO               16'h0000
`define SPDS_DATA_CHARGE_PUMP_OFF    16'h0200
`define SPDS_DATA_CORE_SOFT_RESET    16'h0999
`define SPDS_DATA_CLOCK_GEN_RESET    16'h0009
`define SPDS_DATA_PLL_SOFT_RESET     16'h0099
`define SPDS_CLK_OFF_SER8_PLL        16'h200C
`define SPDS_CLK_OFF_SER8_NOPLL      16'h2008
`define SPDS_CLK_OFF_SER10_PLL       16'h2004
`define SPDS_CLK_OFF_SER10_NOPLL     16'h2000
`define SPDS_CLK_OFF_PAR10           16'h200C

// Sequencer control fields
`define SPDS_SEQ_ENABLE_BIT          0
`define SPDS_SEQ_MODE_MSB            6
`define SPDS_SEQ_MODE_LSB            1

// Bias block occupies addresses 64 to 71: upper six address bits
`define SPDS_BIAS_BLOCK              6'h08

// Variant codes
`define SPDS_VAR_SER8                2'h0
`define SPDS_VAR_SER10               2'h1
`define SPDS_VAR_PAR10               2'h2

// Sequence step indices
`define SPDS_STEP_W                  4
`define SPDS_STEP_DISABLE            4'h0
`define SPDS_STEP_PD_FIRST           4'h1
`define SPDS_STEP_PD_LAST            4'h6
`define SPDS_STEP_CM2_FIRST          4'h7
`define SPDS_STEP_CM2_LAST           4'h9
`define SPDS_STEP_CM1_FIRST          4'hA
`define SPDS_STEP_CM1_LAST           4'hC

// SPI frame: write bit, 9 address bits, 16 data bits
`define SPDS_FRAME_BITS              26
`define SPDS_BIT_CNT_W               5
`define SPDS_SPI_HALF_DIV            5
`define SPDS_DIV_W                   3
`define SPDS_WRITE_FLAG              1'h1
`define SPDS_GAP_CYCLES              4

`endif

// ==== hw/spds_controller.v ====
// Purpose: Drives the sensor through stop, soft power down and clock shutdown over SPI
// Assumes: SPI mode 0, MSB first, frame = write flag, 9-bit address, 16-bit data
// Notes:   The sensor's reset pin is released when a later start, stop or user write frame loads, in the same cycle the clock gate reopens
`timescale 1ns/100ps
`include "spds_defs.vh"

// Function
// - Stop sequencer by writing 192 bit0 zero, keeping mode bits.
// - Soft power down writes 112, 48, 40, 72=0x0200, 64 in order.
// - Last power down write puts 0x0999 into register 10.
// - Clock part 2 writes 34, then variant value to 32, then 9=0x0009.
// - Logic clock off value chosen by output variant and PLL use.
// - Clock part 1 writes 16=0, 8=0x0099, then 20=0.
// - Hold sensor reset asserted before its input clock is stopped.
// - Gain, exposure, windowing changes allowed in any state via user writes.
// - Shutter mode change refused while the sequencer runs.
// - Static registers written only while sequencer enable bit is zero.
// - Sequences write only their documented registers; user writes go to the address given, static ones refused while running.
// - Start sequencer by writing 192 bit0 one with mode bits.
module spds_controller (
   // Clock and reset
   input  wire        sys_clk,
   input  wire        rst,
   // User orders
   input  wire        start_req,
   input  wire        stop_req,
   input  wire        power_down_req,
   input  wire [1:0]  variant,
   input  wire        pll_used,
   input  wire [5:0]  mode_bits,
   input  wire        user_wr_req,
   input  wire [8:0]  user_wr_addr,
   input  wire [15:0] user_wr_data,
   output wire        busy,
   output reg         running,
   output reg         user_wr_refused,
   output reg         power_down_done,
   // Sensor reset and clock gate
   output reg         sensor_reset,
   output reg         sensor_clk_enable,
   // SPI to the sensor
   output reg         spi_sclk,
   output reg         spi_cs_n,
   output reg         spi_mosi
);

   // Top-level states
   localparam [4:0] ST_IDLE  = 5'h01;
   localparam [4:0] ST_LOAD  = 5'h02;
   localparam [4:0] ST_SHIFT = 5'h04;
   localparam [4:0] ST_GAP   = 5'h08;
   localparam [4:0] ST_CLKOFF = 5'h10;

   // Job kinds
   localparam [1:0] JOB_SEQ  = 2'h0;
   localparam [1:0] JOB_USER = 2'h1;
   localparam [1:0] JOB_PD   = 2'h2;

   reg [4:0]                  state;
   reg [1:0]                  job;
   reg [`SPDS_STEP_W-1:0]     step;
   reg                        seq_on;
   reg [`SPDS_FRAME_BITS-1:0] shift;
   reg [`SPDS_BIT_CNT_W-1:0]  bit_cnt;
   reg [`SPDS_DIV_W-1:0]      div;
   reg [2:0]                  gap;
   reg [8:0]                  usr_addr;
   reg [15:0]                 usr_data;

   // Logic clock off value for the variant
   function [15:0] clk_off_value;
      input [1:0] var_sel;
      input       pll;
      begin
         case (var_sel)
            `SPDS_VAR_SER8:  clk_off_value = pll ? `SPDS_CLK_OFF_SER8_PLL
                                                 : `SPDS_CLK_OFF_SER8_NOPLL;
            `SPDS_VAR_SER10: clk_off_value = pll ? `SPDS_CLK_OFF_SER10_PLL
                                                 : `SPDS_CLK_OFF_SER10_NOPLL;
            default:         clk_off_value = `SPDS_CLK_OFF_PAR10;
         endcase
      end
   endfunction

   // Address of a power down step
   function [8:0] step_addr;
      input [`SPDS_STEP_W-1:0] s;
      begin
         case (s)
            4'h1:    step_addr = `SPDS_REG_SERIAL_TX_ENABLE;
            4'h2:    step_addr = `SPDS_REG_FRONT_END_ENABLE;
            4'h3:    step_addr = `SPDS_REG_COLUMN_MUX_ENABLE;
            4'h4:    step_addr = `SPDS_REG_CHARGE_PUMP_ENABLE;
            4'h5:    step_addr = `SPDS_REG_BIAS_ENABLE;
            4'h6:    step_addr = `SPDS_REG_CORE_SOFT_RESET;
            4'h7:    step_addr = `SPDS_REG_LOGIC_BLOCK_ENABLE;
            4'h8:    step_addr = `SPDS_REG_CLOCK_DISTRIBUTION;
            4'h9:    step_addr = `SPDS_REG_CLOCK_GEN_RESET;
            4'hA:    step_addr = `SPDS_REG_PLL_POWER;
            4'hB:    step_addr = `SPDS_REG_PLL_SOFT_RESET;
            4'hC:    step_addr = `SPDS_REG_CLOCK_MGMT_CONFIG;
            default: step_addr = `SPDS_REG_SEQUENCER_CONTROL;
         endcase
      end
   endfunction

   // Data of a power down step
   function [15:0] step_data;
      input [`SPDS_STEP_W-1:0] s;
      input [1:0]              var_sel;
      input                    pll;
      input [5:0]              mode;
      begin
         case (s)
            4'h4:    step_data = `SPDS_DATA_CHARGE_PUMP_OFF;
            4'h6:    step_data = `SPDS_DATA_CORE_SOFT_RESET;
            4'h8:    step_data = clk_off_value(var_sel, pll);
            4'h9:    step_data = `SPDS_DATA_CLOCK_GEN_RESET;
            4'hB:    step_data = `SPDS_DATA_PLL_SOFT_RESET;
            4'h0:    step_data = {9'h000, mode, 1'h0};
            default: step_data = `SPDS_DATA_ZERO;
         endcase
      end
   endfunction

   // Static register check: writable only with the sequencer off
   function is_static;
      input [8:0] a;
      begin
         is_static = (a == `SPDS_REG_CLOCK_DISTRIBUTION) ||
                     (a == `SPDS_REG_COLUMN_MUX_ENABLE) ||
                     (a == `SPDS_REG_FRONT_END_ENABLE) ||
                     (a[8:3] == `SPDS_BIAS_BLOCK) ||
                     (a == `SPDS_REG_SERIAL_TX_ENABLE) ||
                     (a == `SPDS_REG_SEQUENCER_CONTROL);
      end
   endfunction

   assign busy = (state != ST_IDLE);

   // Main sequencing and SPI shifter
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state             <= ST_IDLE;
         job               <= JOB_SEQ;
         step              <= `SPDS_STEP_DISABLE;
         seq_on            <= 1'b0;
         shift             <= {`SPDS_FRAME_BITS{1'b0}};
         bit_cnt           <= {`SPDS_BIT_CNT_W{1'b0}};
         div               <= {`SPDS_DIV_W{1'b0}};
         gap               <= 3'h0;
         usr_addr          <= 9'h000;
         usr_data          <= 16'h0000;
         running           <= 1'b0;
         user_wr_refused   <= 1'b0;
         power_down_done   <= 1'b0;
         sensor_reset      <= 1'b0;
         sensor_clk_enable <= 1'b1;
         spi_sclk          <= 1'b0;
         spi_cs_n          <= 1'b1;
         spi_mosi          <= 1'b0;
      end else begin
         user_wr_refused <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (power_down_req) begin
                  job             <= JOB_PD;
                  step            <= `SPDS_STEP_DISABLE;
                  power_down_done <= 1'b0;
                  state           <= ST_LOAD;
               end else if (stop_req || start_req) begin
                  job    <= JOB_SEQ;
                  step   <= `SPDS_STEP_DISABLE;
                  seq_on <= start_req && !stop_req;
                  state  <= ST_LOAD;
               end else if (user_wr_req) begin
                  // Static registers refused while acquiring; others pass
                  if (running && is_static(user_wr_addr)) begin
                     user_wr_refused <= 1'b1;
                  end else begin
                     job      <= JOB_USER;
                     usr_addr <= user_wr_addr;
                     usr_data <= user_wr_data;
                     state    <= ST_LOAD;
                  end
               end
            end
            ST_LOAD: begin
               sensor_clk_enable <= 1'b1;
               if (job == JOB_USER) begin
                  shift <= {`SPDS_WRITE_FLAG, usr_addr, usr_data};
               end else if (job == JOB_SEQ) begin
                  shift <= {`SPDS_WRITE_FLAG, `SPDS_REG_SEQUENCER_CONTROL,
                            9'h000, mode_bits, seq_on};
               end else begin
                  shift <= {`SPDS_WRITE_FLAG, step_addr(step),
                            step_data(step, variant, pll_used, mode_bits)};
               end
               spi_cs_n <= 1'b0;
               spi_sclk <= 1'b0;
               bit_cnt  <= {`SPDS_BIT_CNT_W{1'b0}};
               div      <= {`SPDS_DIV_W{1'b0}};
               state    <= ST_SHIFT;
            end
            ST_SHIFT: begin
               spi_mosi <= shift[`SPDS_FRAME_BITS-1];
               if (div == `SPDS_SPI_HALF_DIV - 1) begin
                  div      <= {`SPDS_DIV_W{1'b0}};
                  spi_sclk <= ~spi_sclk;
                  if (spi_sclk) begin
                     // Falling edge: advance to the next bit
                     shift <= {shift[`SPDS_FRAME_BITS-2:0], 1'b0};
                     if (bit_cnt == `SPDS_FRAME_BITS - 1) begin
                        spi_cs_n <= 1'b1;
                        gap      <= 3'h0;
                        state    <= ST_GAP;
                     end else begin
                        bit_cnt <= bit_cnt + 5'h01;
                     end
                  end
               end else begin
                  div <= div + 3'h1;
               end
            end
            ST_GAP: begin
               spi_mosi <= 1'b0;
               if (gap == `SPDS_GAP_CYCLES - 1) begin
                  if (job == JOB_PD && step != `SPDS_STEP_CM1_LAST) begin
                     step  <= step + 4'h1;
                     state <= ST_LOAD;
                  end else if (job == JOB_PD) begin
                     running      <= 1'b0;
                     sensor_reset <= 1'b1;
                     state        <= ST_CLKOFF;
                  end else begin
                     if (job == JOB_SEQ) begin
                        running <= seq_on;
                     end
                     state <= ST_IDLE;
                  end
               end else begin
                  gap <= gap + 3'h1;
               end
            end
            ST_CLKOFF: begin
               // Reset already asserted a cycle before the clock gate drops
               sensor_clk_enable <= 1'b0;
               power_down_done   <= 1'b1;
               state             <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
         if (job == JOB_PD && state == ST_GAP && step == `SPDS_STEP_DISABLE) begin
            running <= 1'b0;
         end
         if (state == ST_LOAD && job != JOB_PD) begin
            sensor_reset <= 1'b0;
         end
      end
   end

   // Sequences use only the listed addresses; user writes to static addresses are refused while running, others pass

endmodule

// ==== testbench/spds_sensor_model.sv ====
// Purpose: Sensor register model behind the SPI configuration port
// Assumes: SPI mode 0, frame of write flag, 9-bit address, 16-bit data
// Notes:   Each accepted write shows as a one-cycle pulse with its frame
`timescale 1ns/100ps
module spds_sensor_model (
   // Clock, reset and SPI
   input  wire        sys_clk,
   input  wire        rst,
   input  wire        spi_sclk,
   input  wire        spi_cs_n,
   input  wire        spi_mosi,
   // Accepted write and state
   output reg         wr_pulse,
   output reg  [24:0] wr_frame,
   output wire        running,
   output wire        standby
);
   reg [25:0] sh;
   reg [4:0]  n;
   reg        sclk_d;
   reg        cs_d;
   reg [15:0] regs [0:511];
   // Sequencer state and standby follow the written registers
   assign running = regs[192][0];
   assign standby = regs[10] == 16'h0999;
   // Shift on sclk rise, commit on cs_n rise, any state accepts writes
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wr_pulse <= 1'b0;
         n <= 5'h00;
         sclk_d <= 1'b0;
         cs_d <= 1'b1;
      end else begin
         sclk_d <= spi_sclk;
         cs_d <= spi_cs_n;
         wr_pulse <= 1'b0;
         if (!spi_cs_n && spi_sclk && !sclk_d) begin
            sh <= {sh[24:0], spi_mosi};
            n <= n + 5'h01;
         end
         if (spi_cs_n && !cs_d && n == 5'h1A && sh[25]) begin
            regs[sh[24:16]] <= sh[15:0];
            wr_frame <= sh[24:0];
            wr_pulse <= 1'b1;
         end
         if (spi_cs_n) n <= 5'h00;
      end
   end
endmodule

// ==== testbench/spds_monitor.sv ====
// Purpose: Port assertions for the power down sequencer controller
// Assumes: One clock domain, asynchronous active-high reset
// Notes:   Bound to every controller instance
`timescale 1ns/100ps
module spds_monitor (
   // Clock and reset
   input wire        sys_clk,
   input wire        rst,
   // Orders
   input wire        start_req,
   input wire        stop_req,
   input wire        power_down_req,
   input wire        user_wr_req,
   input wire [8:0]  user_wr_addr,
   // Status
   input wire        busy,
   input wire        running,
   input wire        user_wr_refused,
   input wire        power_down_done,
   input wire        sensor_reset,
   input wire        sensor_clk_enable,
   // SPI
   input wire        spi_sclk,
   input wire        spi_cs_n,
   input wire        spi_mosi
);
   reg  [4:0] nbits;
   reg        sclk_d;
   wire       stat_a;
   wire       wr_only;
   // Static register addresses and a lone user write
   assign stat_a = user_wr_addr[8:3] == 6'h08 || user_wr_addr == 9'h020 || user_wr_addr == 9'h028
                   || user_wr_addr == 9'h030 || user_wr_addr == 9'h070 || user_wr_addr == 9'h0C0;
   assign wr_only = user_wr_req && !power_down_req && !stop_req && !start_req;
   // Count sclk rises inside a frame
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         nbits <= 5'h00;
         sclk_d <= 1'b0;
      end else begin
         sclk_d <= spi_sclk;
         if (spi_cs_n) nbits <= 5'h00;
         else if (spi_sclk && !sclk_d) nbits <= nbits + 5'h01;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   chk_reset_before_gate: assert property ($fell(sensor_clk_enable) |-> sensor_reset)
      else $error("sensor clock gated while out of reset");
   chk_gate_after_reset: assert property ($rose(sensor_reset) |=> !sensor_clk_enable)
      else $error("sensor clock still running after reset");
   chk_done_in_reset: assert property ($rose(power_down_done) |-> sensor_reset)
      else $error("power down done without sensor reset");
   chk_frame_bit_count: assert property ($rose(spi_cs_n) |-> nbits == 5'h1A)
      else $error("frame length not 26 bits");
   chk_write_flag_first: assert property ($fell(spi_cs_n) |=> spi_mosi)
      else $error("frame does not open with write flag");
   chk_mosi_sclk_low: assert property (!spi_cs_n && $changed(spi_mosi) |-> !spi_sclk)
      else $error("mosi changed while sclk high");
   chk_cs_while_busy: assert property (!spi_cs_n |-> busy)
      else $error("frame active while idle");
   chk_static_refused: assert property (!busy && running && wr_only && stat_a |-> ##[1:2] user_wr_refused)
      else $error("static write while running not refused");
   chk_refuse_if_run: assert property (user_wr_refused |-> $past(running))
      else $error("write refused while stopped");
   chk_pd_takes: assert property (!busy && power_down_req |=> busy)
      else $error("power down order not taken");
endmodule
bind spds_controller spds_monitor u_mon (.sys_clk(sys_clk), .rst(rst), .start_req(start_req),
   .stop_req(stop_req), .power_down_req(power_down_req), .user_wr_req(user_wr_req),
   .user_wr_addr(user_wr_addr), .busy(busy), .running(running), .user_wr_refused(user_wr_refused),
   .power_down_done(power_down_done), .sensor_reset(sensor_reset),
   .sensor_clk_enable(sensor_clk_enable), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
   .spi_mosi(spi_mosi));

// ==== testbench/sensor_power_down_sequencer_tb_top.sv ====
// Purpose: Self-checking bench for the power down sequencer controller
// Assumes: Sensor model decodes every SPI write frame
// Notes:   Expected frames queue in order and are popped per write
`timescale 1ns/100ps
module sensor_power_down_sequencer_tb_top;
   localparam [89:0]  STAT_A = {9'h020, 9'h028, 9'h030, 9'h040, 9'h047, 9'h070, 9'h0C0,
                                9'h03F, 9'h048, 9'h0CC};
   localparam [299:0] PD_W = {25'h0140000, 25'h0080099, 25'h0100000, 25'h0090009, 25'h0200000,
      25'h0220000, 25'h00A0999, 25'h0400000, 25'h0480200, 25'h0280000, 25'h0300000, 25'h0700000};
   reg         sys_clk = 1'b0;
   reg         rst = 1'b1;
   reg  [3:0]  reqs = 4'h0;
   reg  [1:0]  variant = 2'h0;
   reg         pll_used = 1'b0;
   reg  [5:0]  mode_bits = 6'h00;
   reg  [8:0]  user_wr_addr = 9'h000;
   reg  [15:0] user_wr_data = 16'h0000;
   reg  [31:0] lfsr_q = 32'h8EA2;
   reg  [24:0] exp_q [$];
   reg         saw_ref = 1'b0;
   wire        busy, running, user_wr_refused, power_down_done, sensor_reset;
   wire        sensor_clk_enable, spi_sclk, spi_cs_n, spi_mosi, wr_pulse, m_running, m_standby;
   wire [24:0] wr_frame;
   integer     n_mismatch = 0, compares = 0, cyc = 0, i, j, k;
   spds_controller uut (.sys_clk(sys_clk), .rst(rst), .start_req(reqs[1]), .stop_req(reqs[2]),
      .power_down_req(reqs[3]), .variant(variant), .pll_used(pll_used), .mode_bits(mode_bits),
      .user_wr_req(reqs[0]), .user_wr_addr(user_wr_addr), .user_wr_data(user_wr_data),
      .busy(busy), .running(running), .user_wr_refused(user_wr_refused),
      .power_down_done(power_down_done), .sensor_reset(sensor_reset),
      .sensor_clk_enable(sensor_clk_enable), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
      .spi_mosi(spi_mosi));
   spds_sensor_model u_sensor (.sys_clk(sys_clk), .rst(rst), .spi_sclk(spi_sclk),
      .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .wr_pulse(wr_pulse), .wr_frame(wr_frame),
      .running(m_running), .standby(m_standby));
   function [31:0] lfsr(input [31:0] x);
      lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // Logic clock off value: parallel fixed, serial by width and PLL use
   function [15:0] clk_off(input [1:0] v, input p);
      clk_off = v[1] ? 16'h200C : {12'h200, ~v[0], p, 2'b00};
   endfunction
   task cmp_frame(input [24:0] got, input [24:0] exp);
      compares = compares + 1;
      if (got !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("[FAIL] %0t frame got %h exp %h", $time, got, exp);
      end
   endtask
   task cmp_flag(input got, input exp);
      compares = compares + 1;
      if (got !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("[FAIL] %0t flag got %h exp %h", $time, got, exp);
      end
   endtask
   task tally_and_finish;
      if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // One-cycle order pulse, then wait for idle under a bound
   task order(input [3:0] sel);
      @(posedge sys_clk);
      reqs <= sel;
      @(posedge sys_clk);
      reqs <= 4'h0;
      repeat (3) @(negedge sys_clk);
      k = 0;
      while (busy !== 1'b0 && k < 5000) begin
         @(negedge sys_clk);
         k = k + 1;
      end
      repeat (3) @(negedge sys_clk);
   endtask
   initial forever #5 sys_clk = ~sys_clk;
   // Refusal capture, timeout and frame comparison
   always @(posedge sys_clk) begin
      cyc = cyc + 1;
      if (user_wr_refused === 1'b1) saw_ref = 1'b1;
      if (cyc == 60000) begin
         n_mismatch = n_mismatch + 1;
         tally_and_finish;
      end
      if (wr_pulse === 1'b1)
         cmp_frame(wr_frame, exp_q.size() > 0 ? exp_q.pop_front() : ~wr_frame);
   end
   initial begin
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      lfsr_q = lfsr(lfsr_q);
      mode_bits <= lfsr_q[5:0];
      exp_q.push_back({9'h0C0, 9'h000, lfsr_q[5:0], 1'b1});
      order(4'h2);
      cmp_flag(running, 1'b1);
      cmp_flag(m_running, 1'b1);
      // Static writes refused while running, others pass
      for (i = 0; i < 10; i = i + 1) begin
         lfsr_q = lfsr(lfsr_q);
         saw_ref = 1'b0;
         @(posedge sys_clk);
         user_wr_addr <= STAT_A[9*i +: 9];
         user_wr_data <= lfsr_q[15:0];
         if (i < 3) exp_q.push_back({STAT_A[9*i +: 9], lfsr_q[15:0]});
         order(4'h1);
         cmp_flag(saw_ref, i >= 3);
      end
      exp_q.push_back({9'h0C0, 9'h000, mode_bits, 1'b0});
      order(4'h4);
      cmp_flag(m_running, 1'b0);
      saw_ref = 1'b0;
      exp_q.push_back({9'h020, user_wr_data});
      order(4'h1);
      cmp_flag(saw_ref, 1'b0);
      exp_q.push_back({9'h0C0, 9'h000, mode_bits, 1'b1});
      order(4'h2);
      // Power down, first from running then from stopped, every variant and PLL choice
      for (i = 0; i < 8; i = i + 1) begin
         @(posedge sys_clk);
         variant <= i[2:1];
         pll_used <= i[0];
         exp_q.push_back({9'h0C0, 9'h000, mode_bits, 1'b0});
         for (j = 0; j < 12; j = j + 1)
            exp_q.push_back(j == 7 ? {9'h020, clk_off(i[2:1], i[0])} : PD_W[25*j +: 25]);
         order(4'h8);
         cmp_flag(sensor_reset, 1'b1);
         cmp_flag(sensor_clk_enable, 1'b0);
         cmp_flag(power_down_done, 1'b1);
         cmp_flag(m_standby, 1'b1);
         cmp_flag(running, 1'b0);
      end
      cmp_flag(exp_q.size() == 0, 1'b1);
      tally_and_finish;
   end
endmodule
